// [pprc_pkg.sv]
package pprc_pkg;
  localparam int CLOCK_NS = 10;
  localparam int STANDBY_IDLE_NS = 70;
  localparam int STANDBY_IDLE_CYC = (STANDBY_IDLE_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int POST_RESET_WAIT_NS = 200;
  localparam int POST_RESET_WAIT_CYC = (POST_RESET_WAIT_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int WARM_RESET_PULSE_NS = 150;
  localparam int WARM_RESET_PULSE_CYC = (WARM_RESET_PULSE_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int CONFIG_LOAD_CYC = 16;
  localparam int TIMER_W = 8;

  localparam logic [7:0] ADDR_PWR_MGMT0 = 8'h00;
  localparam logic [7:0] ADDR_PWR_MGMT2 = 8'h01;
  localparam logic [7:0] ADDR_PORT_DIR = 8'h02;
  localparam logic [7:0] ADDR_PORT_OUT = 8'h03;
  localparam logic [7:0] ADDR_PORT_IN = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h05;

  localparam logic [7:0] REG_RESET = 8'h00;
  // synchroniser reset: warm reset, chip select and both strobes idle high
  localparam logic [10:0] SYNC_IDLE = 11'h780;

  localparam int FAST_MODE_BIT = 3;
  localparam int CLK_ARRAY_BLOCK_BIT = 4;
  localparam int CLK_MCELL_BLOCK_BIT = 5;
  localparam int WR_BLOCK_BIT = 2;
  localparam int RD_BLOCK_BIT = 3;
  localparam int AUX_BLOCK_BIT = 4;
  localparam int PORTD_PIN0_BLOCK_BIT = 5;
  localparam int PORTC_PIN7_BLOCK_BIT = 6;

  localparam int STAT_IN_RESET = 0;
  localparam int STAT_CFG_LOADED = 1;
  localparam int STAT_FLASH_STANDBY = 2;
  localparam int STAT_LOCKOUT = 3;
  localparam int STAT_PLD_STANDBY = 4;
  localparam int STAT_POWER_DOWN = 5;
  localparam int STAT_WRITE_BLOCKED = 6;

  localparam int PLD_IN_W = 6;

  typedef enum logic [1:0] {
    PPRC_CFG_LOAD = 2'b00,
    PPRC_POST_WAIT = 2'b01,
    PPRC_RUN = 2'b11,
    PPRC_WARM_HOLD = 2'b10
  } pprc_state_t;
endpackage

// [pprc_pld_if.sv]
`timescale 1ns/1ps
interface pprc_pld_if #(parameter int ADDR_W = 16);
  logic [pprc_pkg::PLD_IN_W-1:0] pld_in;
  logic [ADDR_W-1:0] addr;
  logic fast_mode_off;
  logic standby;
  modport src (output pld_in, output addr, output fast_mode_off, input standby);
  modport mon (input pld_in, input addr, input fast_mode_off, output standby);
endinterface // pprc_pld_if

// [pprc_cycle_timer.sv]
`timescale 1ns/1ps
module pprc_cycle_timer #(
  parameter int WIDTH = pprc_pkg::TIMER_W
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic run,
  input wire logic [WIDTH-1:0] limit,
  output logic done
);
  logic [WIDTH-1:0] count;

  // counts while run is high, holds at the limit, clears when run drops
  always_ff @(posedge clock) begin
    if (srst || !run) begin
      count <= '0;
    end else if (count != limit) begin
      count <= count + 1'b1;
    end
  end

  assign done = run && (count == limit);
endmodule // pprc_cycle_timer

// [pprc_standby_detect.sv]
`timescale 1ns/1ps
module pprc_standby_detect #(
  parameter int IDLE_CYC = pprc_pkg::STANDBY_IDLE_CYC,
  parameter int ADDR_W = 16
) (
  input wire logic clock,
  input wire logic srst,
  pprc_pld_if.mon pld
);
  logic [pprc_pkg::PLD_IN_W-1:0] prev_in;
  logic [ADDR_W-1:0] prev_addr;
  logic [pprc_pkg::TIMER_W-1:0] idle_count;
  logic changed;

  assign changed = (prev_in != pld.pld_in) || (prev_addr != pld.addr);

  always_ff @(posedge clock) begin
    if (srst) begin
      prev_in <= '0;
      prev_addr <= '0;
    end else begin
      prev_in <= pld.pld_in;
      prev_addr <= pld.addr;
    end
  end

  // standby only with fast mode off and inputs quiet for the idle time
  always_ff @(posedge clock) begin
    if (srst || changed || !pld.fast_mode_off) begin
      idle_count <= '0;
    end else if (idle_count != pprc_pkg::TIMER_W'(IDLE_CYC)) begin
      idle_count <= idle_count + 1'b1;
    end
  end

  assign pld.standby = pld.fast_mode_off && !changed &&
                       (idle_count == pprc_pkg::TIMER_W'(IDLE_CYC));
endmodule // pprc_standby_detect

// [pld_power_and_reset_control.sv]
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
// Contract
// - fast mode bit one: standby after 70 ns idle
// - fast mode bit zero: full power, no standby
// - power management reg0 reads zero after power-up
// - reg2 bit 2 blocks write strobe
// - reg2 bit 3 blocks read strobe
// - reg2 bit 4 blocks aux control input
// - reg2 bit 5 blocks port D pin 0
// - reg2 bit 6 blocks port C pin 7
// - power registers clear only at power-up
// - reg0 bits 4/5 block array/macrocell clock
// - strobes always reach the flash array
// - chip select low enables flash and I/O
// - chip select high: flash standby, logic runs
// - config load, then post-reset wait, no access
// - flash enters read-array at power-up
// - no flash write start below lockout voltage
// - short warm reset accepted, same post wait
// - resets set pins input, clear other registers; warm reset keeps reg0 and reg2
// - power-on clears macrocells; else user equations
// - logic outputs valid in warm reset, after load
// - power-down blocks addresses from logic arrays
module pld_power_and_reset_control #(
  parameter int ADDR_W = 16,
  parameter int PORT_W = 8,
  parameter int MCELL_W = 16,
  parameter int CONFIG_LOAD_CYC = pprc_pkg::CONFIG_LOAD_CYC,
  parameter int POST_RESET_WAIT_CYC = pprc_pkg::POST_RESET_WAIT_CYC,
  parameter int WARM_RESET_PULSE_CYC = pprc_pkg::WARM_RESET_PULSE_CYC,
  parameter int STANDBY_IDLE_CYC = pprc_pkg::STANDBY_IDLE_CYC
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic reset_in_n,
  input wire logic chip_select_in_n,
  input wire logic write_strobe_ctl_n,
  input wire logic read_strobe_ctl_n,
  input wire logic aux_ctl_input,
  input wire logic portd_pin0,
  input wire logic portc_pin7,
  input wire logic pld_clock_in,
  input wire logic supply_lockout,
  input wire logic power_down_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [7:0] flash_sector_selects,
  input wire logic [PORT_W-1:0] port_pins_in,
  output logic [PORT_W-1:0] port_pins_out,
  output logic [PORT_W-1:0] port_pins_oe,
  input wire logic [MCELL_W-1:0] mcell_d,
  input wire logic [MCELL_W-1:0] mcell_user_reset,
  input wire logic [MCELL_W-1:0] mcell_user_preset,
  output logic [MCELL_W-1:0] output_macrocell_q,
  output logic pld_write_strobe_n,
  output logic pld_read_strobe_n,
  output logic pld_aux_ctl,
  output logic pld_portd_pin0,
  output logic pld_portc_pin7,
  output logic pld_array_clock,
  output logic [ADDR_W-1:0] pld_addr,
  output logic pld_standby,
  output logic pld_full_power,
  output logic pld_outputs_valid,
  output logic flash_write_strobe_n,
  output logic flash_read_strobe_n,
  output logic flash_enable,
  output logic flash_standby,
  output logic flash_read_array_reset,
  output logic flash_write_start,
  output logic device_in_reset
);
  localparam int SYNC_W = 11;

  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_pins;
  logic [ADDR_W-1:0] addr_meta;
  logic [ADDR_W-1:0] addr_sync;
  logic [PORT_W-1:0] port_meta;
  logic [PORT_W-1:0] port_sync;

  logic s_reset_n;
  logic s_cs_n;
  logic s_wr_n;
  logic s_rd_n;
  logic s_aux;
  logic s_portd_pin0;
  logic s_portc_pin7;
  logic s_clk;
  logic s_lockout;
  logic s_power_down;

  logic [7:0] pwr_mgmt0;
  logic [7:0] pwr_mgmt2;
  logic [PORT_W-1:0] port_dir;
  logic [PORT_W-1:0] port_out;
  logic [7:0] status;
  logic write_blocked;

  pprc_pkg::pprc_state_t state;
  pprc_pkg::pprc_state_t next_state;

  logic cfg_done;
  logic warm_qualified;
  logic post_done;
  logic warm_clear;
  logic host_selected;
  logic reg_write_ok;
  logic prev_clk;
  logic prev_wr_n;
  logic clk_rise;
  logic wr_fall;

  pprc_pld_if #(.ADDR_W(ADDR_W)) pld_bus ();

  function automatic logic pass_unblocked(input logic sig, input logic [7:0] blk, input int pos);
    pass_unblocked = blk[pos] ? 1'b0 : sig;
  endfunction

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] target);
    addr_is = (a == target);
  endfunction

  // two-stage synchronisers for the control, address and port pins
  always_ff @(posedge clock) begin
    if (srst) begin
      sync_meta <= pprc_pkg::SYNC_IDLE;
      sync_pins <= pprc_pkg::SYNC_IDLE;
      addr_meta <= '0;
      addr_sync <= '0;
      port_meta <= '0;
      port_sync <= '0;
    end else begin
      sync_meta <= {reset_in_n, chip_select_in_n, write_strobe_ctl_n, read_strobe_ctl_n,
                    aux_ctl_input, portd_pin0, portc_pin7, pld_clock_in, supply_lockout,
                    power_down_in, 1'b0};
      sync_pins <= sync_meta;
      addr_meta <= addr_in;
      addr_sync <= addr_meta;
      port_meta <= port_pins_in;
      port_sync <= port_meta;
    end
  end

  assign s_reset_n = sync_pins[10];
  assign s_cs_n = sync_pins[9];
  assign s_wr_n = sync_pins[8];
  assign s_rd_n = sync_pins[7];
  assign s_aux = sync_pins[6];
  assign s_portd_pin0 = sync_pins[5];
  assign s_portc_pin7 = sync_pins[4];
  assign s_clk = sync_pins[3];
  assign s_lockout = sync_pins[2];
  assign s_power_down = sync_pins[1];

  always_ff @(posedge clock) begin
    if (srst) begin
      prev_clk <= 1'b0;
      prev_wr_n <= 1'b1;
    end else begin
      prev_clk <= s_clk;
      prev_wr_n <= s_wr_n;
    end
  end

  assign clk_rise = s_clk && !prev_clk;
  assign wr_fall = !s_wr_n && prev_wr_n;

  // reset sequencing timers
  pprc_cycle_timer #(.WIDTH(pprc_pkg::TIMER_W)) cfg_timer (
    .clock(clock),
    .srst(srst),
    .run(state == pprc_pkg::PPRC_CFG_LOAD),
    .limit(pprc_pkg::TIMER_W'(CONFIG_LOAD_CYC)),
    .done(cfg_done)
  );

  pprc_cycle_timer #(.WIDTH(pprc_pkg::TIMER_W)) warm_timer (
    .clock(clock),
    .srst(srst),
    .run(!s_reset_n),
    .limit(pprc_pkg::TIMER_W'(WARM_RESET_PULSE_CYC)),
    .done(warm_qualified)
  );

  pprc_cycle_timer #(.WIDTH(pprc_pkg::TIMER_W)) post_timer (
    .clock(clock),
    .srst(srst),
    .run(state == pprc_pkg::PPRC_POST_WAIT),
    .limit(pprc_pkg::TIMER_W'(POST_RESET_WAIT_CYC)),
    .done(post_done)
  );

  always_comb begin
    next_state = state;
    case (state)
      pprc_pkg::PPRC_CFG_LOAD: begin
        if (cfg_done && s_reset_n) begin
          next_state = pprc_pkg::PPRC_POST_WAIT;
        end
      end
      pprc_pkg::PPRC_POST_WAIT: begin
        if (!s_reset_n) begin
          next_state = pprc_pkg::PPRC_WARM_HOLD;
        end else if (post_done) begin
          next_state = pprc_pkg::PPRC_RUN;
        end
      end
      pprc_pkg::PPRC_RUN: begin
        if (warm_qualified) begin
          next_state = pprc_pkg::PPRC_WARM_HOLD;
        end
      end
      pprc_pkg::PPRC_WARM_HOLD: begin
        if (s_reset_n) begin
          next_state = pprc_pkg::PPRC_POST_WAIT;
        end
      end
      default: begin
        next_state = pprc_pkg::PPRC_CFG_LOAD;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= pprc_pkg::PPRC_CFG_LOAD;
    end else begin
      state <= next_state;
    end
  end

  assign warm_clear = (state == pprc_pkg::PPRC_WARM_HOLD);
  assign host_selected = !s_cs_n;
  assign reg_write_ok = reg_wr && host_selected && (state == pprc_pkg::PPRC_RUN);

  // power registers cleared by power-up reset only
  always_ff @(posedge clock) begin
    if (srst) begin
      pwr_mgmt0 <= pprc_pkg::REG_RESET;
    end else if (reg_write_ok && addr_is(reg_addr, pprc_pkg::ADDR_PWR_MGMT0)) begin
      pwr_mgmt0 <= reg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pwr_mgmt2 <= pprc_pkg::REG_RESET;
    end else if (reg_write_ok && addr_is(reg_addr, pprc_pkg::ADDR_PWR_MGMT2)) begin
      pwr_mgmt2 <= reg_wdata;
    end
  end

  // port registers cleared by both resets, untouched by power-down
  always_ff @(posedge clock) begin
    if (srst || warm_clear) begin
      port_dir <= '0;
      port_out <= '0;
    end else if (reg_write_ok) begin
      if (addr_is(reg_addr, pprc_pkg::ADDR_PORT_DIR)) begin
        port_dir <= reg_wdata[PORT_W-1:0];
      end
      if (addr_is(reg_addr, pprc_pkg::ADDR_PORT_OUT)) begin
        port_out <= reg_wdata[PORT_W-1:0];
      end
    end
  end

  assign port_pins_oe = port_dir;
  assign port_pins_out = port_out;

  always_comb begin
    status = '0;
    status[pprc_pkg::STAT_IN_RESET] = device_in_reset;
    status[pprc_pkg::STAT_CFG_LOADED] = pld_outputs_valid;
    status[pprc_pkg::STAT_FLASH_STANDBY] = flash_standby;
    status[pprc_pkg::STAT_LOCKOUT] = s_lockout;
    status[pprc_pkg::STAT_PLD_STANDBY] = pld_standby;
    status[pprc_pkg::STAT_POWER_DOWN] = s_power_down;
    status[pprc_pkg::STAT_WRITE_BLOCKED] = write_blocked;
  end

  // read data stands one cycle after the strobe; deselected reads give zero
  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (reg_rd && host_selected) begin
      case (reg_addr)
        pprc_pkg::ADDR_PWR_MGMT0: reg_rdata <= pwr_mgmt0;
        pprc_pkg::ADDR_PWR_MGMT2: reg_rdata <= pwr_mgmt2;
        pprc_pkg::ADDR_PORT_DIR: reg_rdata <= 8'(port_dir);
        pprc_pkg::ADDR_PORT_OUT: reg_rdata <= 8'(port_out);
        pprc_pkg::ADDR_PORT_IN: reg_rdata <= 8'(port_sync);
        pprc_pkg::ADDR_STATUS: reg_rdata <= status;
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // gated inputs to the logic arrays
  always_ff @(posedge clock) begin
    if (srst) begin
      pld_write_strobe_n <= 1'b0;
      pld_read_strobe_n <= 1'b0;
      pld_aux_ctl <= 1'b0;
      pld_portd_pin0 <= 1'b0;
      pld_portc_pin7 <= 1'b0;
      pld_array_clock <= 1'b0;
      pld_addr <= '0;
    end else begin
      pld_write_strobe_n <= pass_unblocked(s_wr_n, pwr_mgmt2, pprc_pkg::WR_BLOCK_BIT);
      pld_read_strobe_n <= pass_unblocked(s_rd_n, pwr_mgmt2, pprc_pkg::RD_BLOCK_BIT);
      pld_aux_ctl <= pass_unblocked(s_aux, pwr_mgmt2, pprc_pkg::AUX_BLOCK_BIT);
      pld_portd_pin0 <= pass_unblocked(s_portd_pin0, pwr_mgmt2,
                                       pprc_pkg::PORTD_PIN0_BLOCK_BIT);
      pld_portc_pin7 <= pass_unblocked(s_portc_pin7, pwr_mgmt2,
                                       pprc_pkg::PORTC_PIN7_BLOCK_BIT);
      pld_array_clock <= pass_unblocked(s_clk, pwr_mgmt0, pprc_pkg::CLK_ARRAY_BLOCK_BIT);
      pld_addr <= s_power_down ? '0 : addr_sync;
    end
  end

  assign pld_bus.pld_in = {pld_write_strobe_n, pld_read_strobe_n, pld_aux_ctl,
                           pld_portd_pin0, pld_portc_pin7, pld_array_clock};
  assign pld_bus.addr = pld_addr;
  assign pld_bus.fast_mode_off = pwr_mgmt0[pprc_pkg::FAST_MODE_BIT];

  pprc_standby_detect #(.IDLE_CYC(STANDBY_IDLE_CYC), .ADDR_W(ADDR_W)) standby_mon (
    .clock(clock),
    .srst(srst),
    .pld(pld_bus.mon)
  );

  assign pld_standby = pld_bus.standby;
  assign pld_full_power = !pwr_mgmt0[pprc_pkg::FAST_MODE_BIT];

  // macrocells: power-up clears, then user reset/preset, then clock
  always_ff @(posedge clock) begin
    if (srst) begin
      output_macrocell_q <= '0;
    end else begin
      for (int i = 0; i < MCELL_W; i++) begin
        if (mcell_user_reset[i]) begin
          output_macrocell_q[i] <= 1'b0;
        end else if (mcell_user_preset[i]) begin
          output_macrocell_q[i] <= 1'b1;
        end else if (clk_rise && !pwr_mgmt0[pprc_pkg::CLK_MCELL_BLOCK_BIT]) begin
          output_macrocell_q[i] <= mcell_d[i];
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pld_outputs_valid <= 1'b0;
    end else begin
      pld_outputs_valid <= (next_state != pprc_pkg::PPRC_CFG_LOAD);
    end
  end

  // flash side
  always_ff @(posedge clock) begin
    if (srst) begin
      flash_write_strobe_n <= 1'b1;
      flash_read_strobe_n <= 1'b1;
      flash_enable <= 1'b0;
      flash_standby <= 1'b1;
      device_in_reset <= 1'b1;
    end else begin
      flash_write_strobe_n <= s_wr_n;
      flash_read_strobe_n <= s_rd_n;
      flash_enable <= host_selected && (next_state == pprc_pkg::PPRC_RUN);
      flash_standby <= s_cs_n;
      device_in_reset <= (next_state != pprc_pkg::PPRC_RUN);
    end
  end

  assign flash_read_array_reset = (state == pprc_pkg::PPRC_CFG_LOAD);

  always_ff @(posedge clock) begin
    if (srst) begin
      flash_write_start <= 1'b0;
      write_blocked <= 1'b0;
    end else begin
      flash_write_start <= wr_fall && host_selected && (|flash_sector_selects) &&
                           !s_lockout && (state == pprc_pkg::PPRC_RUN) &&
                           (next_state == pprc_pkg::PPRC_RUN);
      write_blocked <= wr_fall && host_selected && s_lockout;
    end
  end
endmodule // pld_power_and_reset_control

// [pprc_host_model.sv]
`timescale 1ns/1ps
module pprc_host_model (
  input wire logic clock,
  input wire logic srst,
  input wire logic device_in_reset,
  input wire logic sel,
  input wire logic go_wr,
  output logic chip_select_in_n,
  output logic write_strobe_ctl_n,
  output logic read_strobe_ctl_n,
  output logic [7:0] flash_sector_selects
);
  logic [1:0] hold;
  // no flash cycle is started until the device has left reset
  always_ff @(posedge clock) begin
    if (srst || device_in_reset) begin
      write_strobe_ctl_n <= 1'b1;
      flash_sector_selects <= 8'h00;
      hold <= 2'h0;
    end else if (go_wr && hold == 2'h0) begin
      write_strobe_ctl_n <= 1'b0;
      flash_sector_selects <= 8'h01;
      hold <= 2'h3;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
      if (hold == 2'h1) begin
        write_strobe_ctl_n <= 1'b1;
        flash_sector_selects <= 8'h00;
      end
    end
  end
  always_ff @(posedge clock) chip_select_in_n <= ~sel;
  assign read_strobe_ctl_n = 1'b1;
endmodule // pprc_host_model

// [pprc_props.sv]
`timescale 1ns/1ps
module pprc_props #(
  parameter int ADDR_W = 16,
  parameter int PORT_W = 8,
  parameter int MCELL_W = 16
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic reset_in_n,
  input wire logic write_strobe_ctl_n,
  input wire logic supply_lockout,
  input wire logic power_down_in,
  input wire logic [PORT_W-1:0] port_pins_oe,
  input wire logic [MCELL_W-1:0] output_macrocell_q,
  input wire logic [ADDR_W-1:0] pld_addr,
  input wire logic pld_standby,
  input wire logic pld_full_power,
  input wire logic pld_outputs_valid,
  input wire logic flash_write_strobe_n,
  input wire logic flash_enable,
  input wire logic flash_standby,
  input wire logic flash_read_array_reset,
  input wire logic flash_write_start,
  input wire logic device_in_reset
);
  logic [3:0] rst_age;
  always_ff @(posedge clock) begin
    if (srst) begin
      rst_age <= 4'h0;
    end else if (rst_age != 4'hF) begin
      rst_age <= rst_age + 4'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  sequence warm_low_s;
    !reset_in_n [*8] ##1 !reset_in_n [*4];
  endsequence
  sequence lockout_s;
    supply_lockout [*5];
  endsequence
  reset_state_a:
    assert property (disable iff (1'b0) srst |=> device_in_reset && flash_read_array_reset
      && flash_standby && port_pins_oe == '0 && output_macrocell_q == '0)
    else $error("power-on reset state wrong");
  post_wait_a:
    assert property ($fell(srst) |-> device_in_reset [*8])
    else $error("reset left too early");
  standby_power_a:
    assert property (pld_standby |-> !pld_full_power) else $error("standby at full power");
  strobe_path_a:
    assert property (rst_age == 4'hF |-> flash_write_strobe_n == $past(write_strobe_ctl_n, 3))
    else $error("flash strobe not following pin");
  select_standby_a:
    assert property (flash_enable |-> !flash_standby) else $error("flash enabled in standby");
  lockout_block_a:
    assert property (lockout_s |-> !flash_write_start) else $error("write started in lockout");
  reset_no_write_a:
    assert property (device_in_reset |-> !flash_write_start) else $error("write during reset");
  warm_hold_a:
    assert property (warm_low_s |-> device_in_reset) else $error("warm reset not taken");
  valid_warm_a:
    assert property (pld_outputs_valid |=> pld_outputs_valid) else $error("outputs went invalid");
  pd_addr_a:
    assert property (power_down_in [*5] |-> pld_addr == '0) else $error("address not blocked");
endmodule // pprc_props
bind pld_power_and_reset_control pprc_props #(.ADDR_W(ADDR_W), .PORT_W(PORT_W),
  .MCELL_W(MCELL_W)) pprc_props_u (.clock, .srst, .reset_in_n, .write_strobe_ctl_n,
  .supply_lockout, .power_down_in, .port_pins_oe, .output_macrocell_q, .pld_addr,
  .pld_standby, .pld_full_power, .pld_outputs_valid, .flash_write_strobe_n, .flash_enable,
  .flash_standby, .flash_read_array_reset, .flash_write_start, .device_in_reset);

// [tb_pld_power_and_reset_control.sv]
`timescale 1ns/1ps
module tb_pld_power_and_reset_control;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic reg_wr = 1'b0, reg_rd = 1'b0, reset_in_n = 1'b1, sel = 1'b1, go_wr = 1'b0;
  logic aux_ctl_input = 1'b1, portd_pin0 = 1'b1, portc_pin7 = 1'b1, pld_clock_in = 1'b0;
  logic supply_lockout = 1'b0, power_down_in = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [15:0] addr_in = 16'h0000, mcell_d = 16'h0000, mcell_user_rst = 16'h0000;
  logic [7:0] rd_v, reg_rdata, port_pins_oe, flash_sector_selects;
  logic [15:0] output_macrocell_q, pld_addr;
  logic chip_select_in_n, write_strobe_ctl_n, read_strobe_ctl_n, pld_write_strobe_n;
  logic pld_read_strobe_n, pld_aux_ctl, pld_portd_pin0, pld_portc_pin7, pld_array_clock;
  logic pld_standby, pld_full_power, flash_enable, flash_standby, flash_read_array_reset;
  logic flash_write_start, device_in_reset, pld_outputs_valid, flash_write_strobe_n;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_start = 0;
  int base;

  pld_power_and_reset_control #(.CONFIG_LOAD_CYC(4), .POST_RESET_WAIT_CYC(4),
    .WARM_RESET_PULSE_CYC(3)) dut_u (.clock, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .reset_in_n, .chip_select_in_n, .write_strobe_ctl_n, .read_strobe_ctl_n,
    .aux_ctl_input, .portd_pin0, .portc_pin7, .pld_clock_in, .supply_lockout, .power_down_in,
    .addr_in, .flash_sector_selects, .port_pins_in(8'h00), .port_pins_out(), .port_pins_oe,
    .mcell_d, .mcell_user_reset(mcell_user_rst), .mcell_user_preset(16'h0000), .output_macrocell_q,
    .pld_write_strobe_n, .pld_read_strobe_n, .pld_aux_ctl, .pld_portd_pin0, .pld_portc_pin7,
    .pld_array_clock, .pld_addr, .pld_standby, .pld_full_power, .pld_outputs_valid,
    .flash_write_strobe_n, .flash_read_strobe_n(), .flash_enable, .flash_standby,
    .flash_read_array_reset, .flash_write_start, .device_in_reset);
  pprc_host_model host_u (.clock, .srst, .device_in_reset, .sel, .go_wr, .chip_select_in_n,
    .write_strobe_ctl_n, .read_strobe_ctl_n, .flash_sector_selects);

  initial forever #5 clock = ~clock;
  always @(posedge clock) if (flash_write_start === 1'b1) n_start++;

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string w, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic chk1(input string w, input logic seen, input logic exp);
    check(w, {15'h0000, seen}, {15'h0000, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input string w, input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    rd_v = reg_rdata;
    check(w, {8'h00, rd_v}, {8'h00, e});
  endtask
  task automatic wait_ready();
    int i;
    for (i = 0; i < 300 && device_in_reset !== 1'b0; i++) @(posedge clock);
    chk1("in_reset", device_in_reset, 1'b0);
    if (device_in_reset !== 1'b0) results();
  endtask
  task automatic host_write(input logic [15:0] e);
    base = n_start;
    go_wr <= 1'b1;
    cyc(1);
    go_wr <= 1'b0;
    cyc(4);
    chk1("flash_wr", flash_write_strobe_n, 1'b0);
    cyc(8);
    check("write_starts", 16'(n_start - base), e);
  endtask

  initial begin
    cyc(6);
    srst <= 1'b0;
    wait_ready();
    chk1("flash_enable", flash_enable, 1'b1);
    rchk("reg0", pprc_pkg::ADDR_PWR_MGMT0, 8'h00);
    rchk("reg2", pprc_pkg::ADDR_PWR_MGMT2, 8'h00);
    rchk("unmapped", 8'h7F, 8'h00);
    $display("test reset_values done");
    for (int i = 0; i < 5; i++) begin
      wr(pprc_pkg::ADDR_PWR_MGMT2, 8'(8'h04 << i));
      cyc(4);
      check("gated", {11'h000, pld_write_strobe_n, pld_read_strobe_n, pld_aux_ctl,
        pld_portd_pin0, pld_portc_pin7}, {11'h000, ~(5'h10 >> i)});
    end
    rchk("reg2", pprc_pkg::ADDR_PWR_MGMT2, 8'h40);
    $display("test blocking done");
    mcell_d <= 16'hFFFF;
    wr(pprc_pkg::ADDR_PWR_MGMT0, 8'h30);
    pld_clock_in <= 1'b1;
    cyc(5);
    chk1("array_clock", pld_array_clock, 1'b0);
    check("mcell_q", output_macrocell_q, 16'h0000);
    pld_clock_in <= 1'b0;
    wr(pprc_pkg::ADDR_PWR_MGMT0, 8'h00);
    cyc(4);
    pld_clock_in <= 1'b1;
    cyc(5);
    chk1("array_clock", pld_array_clock, 1'b1);
    check("mcell_q", output_macrocell_q, 16'hFFFF);
    $display("test clock_block done");
    cyc(8);
    chk1("standby", pld_standby, 1'b0);
    chk1("full_power", pld_full_power, 1'b1);
    wr(pprc_pkg::ADDR_PWR_MGMT0, 8'h08);
    cyc(12);
    chk1("standby", pld_standby, 1'b1);
    chk1("full_power", pld_full_power, 1'b0);
    aux_ctl_input <= 1'b0;
    cyc(5);
    chk1("standby", pld_standby, 1'b0);
    wr(pprc_pkg::ADDR_PWR_MGMT0, 8'h00);
    $display("test fast_mode done");
    wr(pprc_pkg::ADDR_PWR_MGMT2, 8'h04);
    host_write(16'h0001);
    supply_lockout <= 1'b1;
    cyc(4);
    host_write(16'h0000);
    rchk("status", pprc_pkg::ADDR_STATUS, 8'h0A);
    supply_lockout <= 1'b0;
    $display("test flash_write done");
    sel <= 1'b0;
    aux_ctl_input <= 1'b1;
    cyc(5);
    chk1("flash_standby", flash_standby, 1'b1);
    chk1("flash_enable", flash_enable, 1'b0);
    chk1("aux", pld_aux_ctl, 1'b1);
    wr(pprc_pkg::ADDR_PWR_MGMT0, 8'h08);
    sel <= 1'b1;
    cyc(4);
    rchk("reg0", pprc_pkg::ADDR_PWR_MGMT0, 8'h00);
    $display("test chip_select done");
    wr(pprc_pkg::ADDR_PWR_MGMT0, 8'h08);
    wr(pprc_pkg::ADDR_PORT_DIR, 8'hFF);
    cyc(3);
    check("port_oe", {8'h00, port_pins_oe}, 16'h00FF);
    reset_in_n <= 1'b0;
    cyc(14);
    chk1("in_reset", device_in_reset, 1'b1);
    chk1("outputs_valid", pld_outputs_valid, 1'b1);
    reset_in_n <= 1'b1;
    cyc(3);
    wait_ready();
    check("port_oe", {8'h00, port_pins_oe}, 16'h0000);
    check("mcell_q", output_macrocell_q, 16'hFFFF);
    mcell_user_rst <= 16'h00FF;
    cyc(2);
    check("mcell_q", output_macrocell_q, 16'hFF00);
    mcell_user_rst <= 16'h0000;
    rchk("reg0", pprc_pkg::ADDR_PWR_MGMT0, 8'h08);
    rchk("port_dir", pprc_pkg::ADDR_PORT_DIR, 8'h00);
    $display("test warm_reset done");
    addr_in <= 16'hA5A5;
    cyc(5);
    check("pld_addr", pld_addr, 16'hA5A5);
    power_down_in <= 1'b1;
    cyc(6);
    check("pld_addr", pld_addr, 16'h0000);
    rchk("reg0", pprc_pkg::ADDR_PWR_MGMT0, 8'h08);
    power_down_in <= 1'b0;
    $display("test power_down done");
    srst <= 1'b1;
    cyc(2);
    chk1("read_array", flash_read_array_reset, 1'b1);
    check("mcell_q", output_macrocell_q, 16'h0000);
    chk1("outputs_valid", pld_outputs_valid, 1'b0);
    srst <= 1'b0;
    wait_ready();
    rchk("reg0", pprc_pkg::ADDR_PWR_MGMT0, 8'h00);
    $display("test power_on done");
    results();
  end
endmodule // tb_pld_power_and_reset_control
